// ==== core/tmw_timer.sv ====
// 8-bit timer waveform and clock-select control with a Wishbone slave
// What this block does
// - nonzero output mode routes wave output to pin; driver needs direction bit.
// - non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - fast PWM code 01 on A: level held, pin still routed, if mode high 0; toggle if 1.
// - fast PWM 10 clear on match set at bottom; 11 inverse; B 01 reserved.
// - fast PWM compare equal TOP with upper bit: ignore match, act at bottom.
// - phase PWM B: 10 clears up, sets down; 11 opposite; 01 reserved.
// - phase PWM compare equal TOP with upper bit: ignore match, act at TOP.
// - unused control bits 3:2 and 5:4 always read zero.
// - waveform mode is second register bit 3 over first register bits 1:0.
// - modes 0,2 immediate update, flag MAX; 1 top/bottom; 3 bottom/MAX.
// - modes 2,5,7 take TOP from compare A; 4 and 6 reserved.
// - MAX is 0xFF and BOTTOM is 0x00.
// - force strobe in non-PWM applies current compare action at once.
// - forced compare sets no flag, clears no counter; strobes read zero.
// - clock codes 000 stop, 001 undivided, 010 /8, 011 /32.
// - output mode change acts at next match, or at the PWM bottom/TOP event, unless forced.
// - source clock is system clock, or oscillator pin when async selected.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tmw_consts.svh"
`default_nettype none
module tmw_timer
    import tmw_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osc_pin_i,
    input wire logic dir_a_i,
    input wire logic dir_b_i,
    output logic override_a_o,
    output logic override_b_o,
    output logic wave_a_o,
    output logic wave_b_o,
    output logic wave_a_oe_o,
    output logic wave_b_oe_o
);
    if (ADDR_W < 8) begin : g_chk
        $error("tmw_timer: ADDR_W must be at least 8");
    end

    tmw_state_t q, n;
    logic fast, pc, pwm, clear_on_match_mode, src, tick, at_top, ma, mb, top_ev;
    logic req, wr, fa, fb, cmpa_top, cmpb_top;
    logic [7:0] top, addr, wbyte;
    logic [9:0] mask;

    // prescaler mask per clock code, period equals divide ratio
    function automatic logic [9:0] div_mask(input logic [2:0] cs);
        unique case (cs)
            `TMW_CS_DIV8: div_mask = 10'h007;
            `TMW_CS_DIV32: div_mask = 10'h01F;
            `TMW_CS_DIV64: div_mask = 10'h03F;
            `TMW_CS_DIV128: div_mask = 10'h07F;
            `TMW_CS_DIV256: div_mask = 10'h0FF;
            `TMW_CS_DIV1024: div_mask = 10'h3FF;
            default: div_mask = 10'h000;
        endcase
    endfunction

    // next level of one wave output for the current events
    function automatic logic wave_step(input logic cur, input logic [1:0] com,
        input logic is_a, input logic wmh, input logic f, input logic p, input logic dn,
        input logic mt, input logic tev, input logic ot);
        wave_step = cur;
        if (f) begin
            if (tev && com[1]) begin
                wave_step = ~com[0];
            end else if (mt && com[1] && !ot) begin
                wave_step = com[0];
            end else if (mt && com == `TMW_COM_TOGGLE && is_a && wmh) begin
                wave_step = ~cur;
            end
        end else if (p) begin
            if (com[1] && ot) begin
                if (tev) begin
                    wave_step = ~com[0];
                end
            end else if (mt && com[1]) begin
                wave_step = dn ? ~com[0] : com[0];
            end else if (mt && com == `TMW_COM_TOGGLE && is_a && wmh) begin
                wave_step = ~cur;
            end
        end else if (mt) begin
            unique case (com)
                `TMW_COM_TOGGLE: wave_step = ~cur;
                `TMW_COM_CLEAR: wave_step = 1'b0;
                `TMW_COM_SET: wave_step = 1'b1;
                default: wave_step = cur;
            endcase
        end
    endfunction

    // mode decode and timebase
    assign fast = q.wm == `TMW_WM_FAST_FF || q.wm == `TMW_WM_FAST_OCA;
    assign pc = q.wm == `TMW_WM_PC_FF || q.wm == `TMW_WM_PC_OCA;
    assign pwm = fast | pc;
    assign clear_on_match_mode = q.wm == `TMW_WM_CTC;
    assign top = (clear_on_match_mode || q.wm == `TMW_WM_PC_OCA || q.wm == `TMW_WM_FAST_OCA)
        ? q.cmpa : `TMW_MAX;
    assign src = q.asel ? (q.s2 & ~q.s3) : 1'b1;
    assign mask = div_mask(q.cs);
    assign tick = src && q.cs != `TMW_CS_STOP && (q.pre & mask) == mask;
    assign at_top = q.cnt == top;
    assign ma = tick && q.cnt == q.cmpa;
    assign mb = tick && q.cnt == q.cmpb;
    assign top_ev = tick && at_top && (fast || (pc && !q.down));
    assign cmpa_top = q.cmpa == top;
    assign cmpb_top = q.cmpb == top;

    // bus decode; writes land on the edge where the master sees ack
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && wb_we_i && q.ack && wb_sel_i[0];
    assign addr = wb_adr_i[7:0];
    assign wbyte = wb_dat_i[7:0];
    assign fa = wr && addr == `TMW_OFF_CTRL_B && wbyte[`TMW_BIT_FORCE_A] && !pwm;
    assign fb = wr && addr == `TMW_OFF_CTRL_B && wbyte[`TMW_BIT_FORCE_B] && !pwm;

    // whole next state
    always_comb begin
        n = q;
        n.s1 = osc_pin_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (src && q.cs != `TMW_CS_STOP) begin
            n.pre = q.pre + 10'h001;
        end
        // counting sequence
        if (tick) begin
            if (pc) begin
                if (!q.down) begin
                    n.cnt = at_top ? q.cnt - 8'h01 : q.cnt + 8'h01;
                    n.down = at_top;
                end else if (q.cnt == `TMW_BOTTOM) begin
                    n.cnt = q.cnt + 8'h01;
                    n.down = 1'b0;
                end else begin
                    n.cnt = q.cnt - 8'h01;
                end
            end else begin
                n.cnt = at_top ? `TMW_BOTTOM : q.cnt + 8'h01;
            end
        end
        // compare buffer transfer point
        if (!pwm || top_ev) begin
            n.cmpa = q.cmpa_buf;
            n.cmpb = q.cmpb_buf;
        end
        // waveform outputs, force uses the mode bits already in place
        n.wa = wave_step(q.wa, q.com_a, 1'b1, q.wm[2], fast, pc, q.down, ma | fa,
            top_ev, cmpa_top);
        n.wb = wave_step(q.wb, q.com_b, 1'b0, q.wm[2], fast, pc, q.down, mb | fb,
            top_ev, cmpb_top);
        // register writes
        if (wr) begin
            unique case (addr)
                `TMW_OFF_CTRL_A: begin
                    n.com_a = wbyte[7:6];
                    n.com_b = wbyte[5:4];
                    n.wm[1:0] = wbyte[1:0];
                end
                `TMW_OFF_CTRL_B: begin
                    n.wm[2] = wbyte[`TMW_BIT_WM_HIGH];
                    n.cs = wbyte[2:0];
                end
                `TMW_OFF_CMP_A: n.cmpa_buf = wbyte;
                `TMW_OFF_CMP_B: n.cmpb_buf = wbyte;
                `TMW_OFF_COUNT: n.cnt = wbyte;
                `TMW_OFF_CFG: n.asel = wbyte[`TMW_BIT_ASYNC];
                `TMW_OFF_FLAGS: begin
                    n.ovf = q.ovf & ~wbyte[`TMW_BIT_OVF];
                    n.mfa = q.mfa & ~wbyte[`TMW_BIT_MATCH_A];
                    n.mfb = q.mfb & ~wbyte[`TMW_BIT_MATCH_B];
                end
                default: n.cs = q.cs;
            endcase
        end
        // sticky flags, a set beats a clear; forces never set them
        if (pc ? (tick && q.down && q.cnt == `TMW_BOTTOM)
            : (q.wm == `TMW_WM_FAST_OCA ? top_ev : (tick && q.cnt == `TMW_MAX))) begin
            n.ovf = 1'b1;
        end
        if (ma) begin
            n.mfa = 1'b1;
        end
        if (mb) begin
            n.mfb = 1'b1;
        end
        // single-cycle ack with registered read data
        n.ack = req && !q.ack;
        n.dat = 32'h0000_0000;
        if (req && !q.ack && !wb_we_i) begin
            unique case (addr)
                `TMW_OFF_CTRL_A: n.dat[7:0] = {q.com_a, q.com_b, 2'b00, q.wm[1:0]};
                `TMW_OFF_CTRL_B: n.dat[7:0] = {4'h0, q.wm[2], q.cs};
                `TMW_OFF_CMP_A: n.dat[7:0] = q.cmpa_buf;
                `TMW_OFF_CMP_B: n.dat[7:0] = q.cmpb_buf;
                `TMW_OFF_COUNT: n.dat[7:0] = q.cnt;
                `TMW_OFF_CFG: n.dat[7:0] = {7'h00, q.asel};
                `TMW_OFF_FLAGS: n.dat[7:0] = {5'h00, q.mfb, q.mfa, q.ovf};
                default: n.dat = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // pin side
    assign override_a_o = |q.com_a;
    assign override_b_o = |q.com_b;
    assign wave_a_oe_o = (|q.com_a) & dir_a_i;
    assign wave_b_oe_o = (|q.com_b) & dir_b_i;
    assign wave_a_o = q.wa;
    assign wave_b_o = q.wb;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;

    ack_single_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wb_ack_o && $past(addr == `TMW_OFF_CTRL_A && !wb_we_i))
        |-> wb_dat_o[3:2] == 2'b00) else $error("reserved bits read nonzero");
    pin_release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.com_a == `TMW_COM_OFF) |-> !wave_a_oe_o && !override_a_o)
        else $error("pin driven while disconnected");
    nonpwm_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!pwm && ma && q.com_a == `TMW_COM_CLEAR) |=> !wave_a_o)
        else $error("clear on match missed");
    fast_bottom_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fast && top_ev && q.com_a == `TMW_COM_CLEAR) |=> wave_a_o)
        else $error("bottom set missed");
    phase_up_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pc && mb && !q.down && !cmpb_top && q.com_b == `TMW_COM_SET) |=> wave_b_o)
        else $error("up-count set missed");
    force_noflag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fa && !ma && !q.mfa) |=> !q.mfa) else $error("force set a flag");
    undivided_tick_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.cs == `TMW_CS_DIV1 && !q.asel) |-> tick) else $error("undivided tick lost");
    phase_ovf_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pc && tick && q.down && q.cnt == `TMW_BOTTOM) |=> q.ovf)
        else $error("bottom overflow missed");
    immediate_cmp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!pwm && !$past(pwm)) |-> q.cmpa == $past(q.cmpa_buf))
        else $error("compare not immediate");

    // clock select: a stopped code never ticks
    cs_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.cs == `TMW_CS_STOP) |-> !tick) else $error("tick while stopped");

    // divide by eight ticks once per eight prescaler states
    div8_tick_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.cs == `TMW_CS_DIV8 && !q.asel) |-> tick == (q.pre[2:0] == 3'h7))
        else $error("divide by eight tick wrong");

    // async source: no tick without a synchronised rising edge
    async_src_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.asel && !(q.s2 && !q.s3)) |-> !tick)
        else $error("async tick without edge");

    // force strobes and reserved bits read back zero
    force_read_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wb_ack_o && $past(addr == `TMW_OFF_CTRL_B && !wb_we_i))
        |-> wb_dat_o[7:4] == 4'h0) else $error("strobe bits read nonzero");

    // driver enable only with direction bit and override
    oe_dir_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wave_b_oe_o |-> dir_b_i && override_b_o)
        else $error("driver enabled without direction");

    // waveform mode high bit lands from the second register
    mode_high_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr && addr == `TMW_OFF_CTRL_B) |=> q.wm[2] == $past(wb_dat_i[3]))
        else $error("mode high bit not stored");

    // clear-on-match returns the count to bottom at compare A
    ctc_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (clear_on_match_mode && tick && q.cnt == q.cmpa && !wr) |=> q.cnt == `TMW_BOTTOM)
        else $error("clear on match wrap missed");

    // normal mode wraps from MAX to bottom
    max_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.wm == `TMW_WM_NORMAL && tick && q.cnt == `TMW_MAX && !wr)
        |=> q.cnt == `TMW_BOTTOM) else $error("max wrap missed");

    // non-pwm toggle flips the output on a match
    nonpwm_toggle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!pwm && ma && !fa && q.com_a == `TMW_COM_TOGGLE) |=> wave_a_o != $past(wave_a_o))
        else $error("toggle on match missed");

    // phase pwm channel A sets on a down-count match
    phase_down_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pc && ma && q.down && !cmpa_top && q.com_a == `TMW_COM_CLEAR) |=> wave_a_o)
        else $error("down-count set missed");

    // pwm modes hold the active compare until the update point
    pwm_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pwm && !top_ev) |=> q.cmpa == $past(q.cmpa))
        else $error("compare updated early");
endmodule
`default_nettype wire

// ==== core/tmw_consts.svh ====
// register map, field positions and fixed values of the 8-bit timer control block
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH
`define TMW_OFF_CTRL_A 8'h00
`define TMW_OFF_CTRL_B 8'h04
`define TMW_OFF_CMP_A 8'h08
`define TMW_OFF_CMP_B 8'h0C
`define TMW_OFF_COUNT 8'h10
`define TMW_OFF_CFG 8'h14
`define TMW_OFF_FLAGS 8'h18
`define TMW_RST_BYTE 8'h00
`define TMW_MAX 8'hFF
`define TMW_BOTTOM 8'h00
`define TMW_WM_NORMAL 3'h0
`define TMW_WM_PC_FF 3'h1
`define TMW_WM_CTC 3'h2
`define TMW_WM_FAST_FF 3'h3
`define TMW_WM_PC_OCA 3'h5
`define TMW_WM_FAST_OCA 3'h7
`define TMW_CS_STOP 3'h0
`define TMW_CS_DIV1 3'h1
`define TMW_CS_DIV8 3'h2
`define TMW_CS_DIV32 3'h3
`define TMW_CS_DIV64 3'h4
`define TMW_CS_DIV128 3'h5
`define TMW_CS_DIV256 3'h6
`define TMW_CS_DIV1024 3'h7
`define TMW_COM_OFF 2'h0
`define TMW_COM_TOGGLE 2'h1
`define TMW_COM_CLEAR 2'h2
`define TMW_COM_SET 2'h3
`define TMW_BIT_FORCE_A 7
`define TMW_BIT_FORCE_B 6
`define TMW_BIT_WM_HIGH 3
`define TMW_BIT_ASYNC 0
`define TMW_BIT_OVF 0
`define TMW_BIT_MATCH_A 1
`define TMW_BIT_MATCH_B 2
`endif

// ==== core/tmw_pkg.sv ====
// types of the 8-bit timer control block
package tmw_pkg;
    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] wm;
        logic [2:0] cs;
        logic [7:0] cmpa_buf;
        logic [7:0] cmpb_buf;
        logic [7:0] cmpa;
        logic [7:0] cmpb;
        logic [7:0] cnt;
        logic down;
        logic [9:0] pre;
        logic asel;
        logic ovf;
        logic mfa;
        logic mfb;
        logic wa;
        logic wb;
        logic s1;
        logic s2;
        logic s3;
        logic ack;
        logic [31:0] dat;
    } tmw_state_t;
endpackage

// ==== dv/tb_top.sv ====
// self-checking bench for the 8-bit timer control block
`timescale 1ns/1ps
`include "tmw_consts.svh"
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic osc = 1'b0;
    logic dira = 1'b1;
    logic dirb = 1'b0;
    logic [31:0] rdat;
    logic ack, ova, ovb, wva, wvb, oea, oeb;
    logic [31:0] r;
    int mismatches = 0;
    int comparisons = 0;
    int h;
    logic [7:0] codes [4] = '{8'h3, 8'h1, 8'h2, 8'h1};
    logic exps [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    tmw_timer dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .osc_pin_i(osc), .dir_a_i(dira), .dir_b_i(dirb),
        .override_a_o(ova), .override_b_o(ovb), .wave_a_o(wva), .wave_b_o(wvb),
        .wave_a_oe_o(oea), .wave_b_oe_o(oeb));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // verdict and end of run
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic wishbone cycle, waits for ack under a bound
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                summarize();
            end
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wbx(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wbx(1'b0, a, 32'h0, q);
        check(q, {24'h0, e});
    endtask

    // high cycles of one wave output over n cycles
    task automatic duty(input int n, input logic b, output int hc);
        hc = 0;
        repeat (n) begin
            @(posedge clk_i);
            hc += int'(b ? wvb : wva);
        end
    endtask

    function automatic logic near(input int v, input int e);
        return (v >= e - 4) && (v <= e + 4);
    endfunction

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        check({ova, ovb, wva, wvb, oea, oeb}, 6'h00);
        rd(`TMW_OFF_CTRL_A, 8'h00);
        wr(`TMW_OFF_CTRL_A, 8'hFF);
        rd(`TMW_OFF_CTRL_A, 8'hF3);
        wr(`TMW_OFF_CTRL_B, 8'h3F);
        rd(`TMW_OFF_CTRL_B, 8'h0F);
        rd(8'h1C, 8'h00);
        wr(`TMW_OFF_CTRL_B, 8'h00);
        // forced compare per code, both channels, counter stopped
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                wr(`TMW_OFF_CTRL_A, c ? codes[k] << 4 : codes[k] << 6);
                wr(`TMW_OFF_CTRL_B, c ? 8'h40 : 8'h80);
                check(c ? wvb : wva, exps[k]);
                check({ova, ovb, oea, oeb}, c ? 4'b0100 : 4'b1010);
            end
        end
        rd(`TMW_OFF_FLAGS, 8'h00);
        rd(`TMW_OFF_CTRL_B, 8'h00);
        // toggle on a real match, then overflow at MAX
        wr(`TMW_OFF_CTRL_A, 8'h40);
        wr(`TMW_OFF_CMP_A, 8'h10);
        wr(`TMW_OFF_CMP_B, 8'h20);
        wr(`TMW_OFF_COUNT, 8'h00);
        wr(`TMW_OFF_CTRL_B, 8'h01);
        repeat (50) @(posedge clk_i);
        wr(`TMW_OFF_CTRL_B, 8'h00);
        check(wva, 1'b0);
        rd(`TMW_OFF_FLAGS, 8'h06);
        wr(`TMW_OFF_FLAGS, 8'h07);
        wr(`TMW_OFF_CTRL_B, 8'h01);
        repeat (260) @(posedge clk_i);
        wr(`TMW_OFF_CTRL_B, 8'h00);
        wbx(1'b0, `TMW_OFF_FLAGS, 32'h0, r);
        check(r[0], 1'b1);
        // clear-on-match keeps the count at or below compare A
        wr(`TMW_OFF_CTRL_A, 8'h02);
        wr(`TMW_OFF_CMP_A, 8'h20);
        wr(`TMW_OFF_COUNT, 8'h00);
        wr(`TMW_OFF_CTRL_B, 8'h01);
        repeat (200) @(posedge clk_i);
        wr(`TMW_OFF_CTRL_B, 8'h00);
        wbx(1'b0, `TMW_OFF_COUNT, 32'h0, r);
        check(r <= 32'h20, 1'b1);
        wr(`TMW_OFF_COUNT, 8'h10);
        wr(`TMW_OFF_CTRL_B, 8'h80);
        rd(`TMW_OFF_COUNT, 8'h10);
        // clock select codes: about 20 ticks per run
        wr(`TMW_OFF_CTRL_A, 8'h00);
        for (int i = 1; i < 8; i++) begin
            wr(`TMW_OFF_COUNT, 8'h00);
            wr(`TMW_OFF_CTRL_B, 8'(i));
            repeat (divs[i] * 20) @(posedge clk_i);
            wr(`TMW_OFF_CTRL_B, 8'h00);
            wbx(1'b0, `TMW_OFF_COUNT, 32'h0, r);
            check(r >= 19 && r <= 23, 1'b1);
        end
        // oscillator pin as source
        wr(`TMW_OFF_CFG, 8'h01);
        wr(`TMW_OFF_COUNT, 8'h00);
        wr(`TMW_OFF_CTRL_B, 8'h01);
        repeat (10) begin
            osc <= 1'b1;
            repeat (4) @(posedge clk_i);
            osc <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        wr(`TMW_OFF_CTRL_B, 8'h00);
        rd(`TMW_OFF_COUNT, 8'h0A);
        wr(`TMW_OFF_CFG, 8'h00);
        // fast pwm: A non-inverting, B inverting, then A at TOP
        wr(`TMW_OFF_CMP_A, 8'h80);
        wr(`TMW_OFF_CMP_B, 8'h40);
        wr(`TMW_OFF_CTRL_A, 8'hB3);
        wr(`TMW_OFF_CTRL_B, 8'h01);
        repeat (300) @(posedge clk_i);
        duty(512, 1'b0, h);
        check(near(h, 258), 1'b1);
        duty(512, 1'b1, h);
        check(near(h, 382), 1'b1);
        wr(`TMW_OFF_CMP_A, 8'hFF);
        repeat (300) @(posedge clk_i);
        duty(512, 1'b0, h);
        check(near(h, 512), 1'b1);
        // phase-correct pwm
        wr(`TMW_OFF_CTRL_B, 8'h00);
        wr(`TMW_OFF_CMP_A, 8'h80);
        wr(`TMW_OFF_CTRL_A, 8'hB1);
        wr(`TMW_OFF_CTRL_B, 8'h01);
        repeat (600) @(posedge clk_i);
        duty(510, 1'b0, h);
        check(near(h, 256), 1'b1);
        duty(510, 1'b1, h);
        check(near(h, 382), 1'b1);
        wr(`TMW_OFF_CMP_A, 8'hFF);
        repeat (600) @(posedge clk_i);
        duty(510, 1'b0, h);
        check(near(h, 510), 1'b1);
        // fast pwm with TOP from compare A, A toggles
        wr(`TMW_OFF_CTRL_B, 8'h00);
        wr(`TMW_OFF_CMP_A, 8'h09);
        wr(`TMW_OFF_CTRL_A, 8'h43);
        wr(`TMW_OFF_CTRL_B, 8'h09);
        repeat (400) @(posedge clk_i);
        duty(400, 1'b0, h);
        check(near(h, 200), 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
